// File: core/port_config_pkg.sv
package port_config_pkg;

    // Core clock
    localparam int CLK_PERIOD_PS = 25000;

    // Downstream port range
    localparam int NUM_PORTS     = 4;
    localparam int FIRST_DOWN    = 1;
    localparam int LAST_DOWN     = 3;

    // Max payload size capability codes
    localparam logic [2:0] MPS_CODE_256 = 3'h1;
    localparam logic [2:0] MPS_CODE_512 = 3'h2;
    localparam logic [2:0] MPS_RESET    = 3'h0;

    // Reference clock and PLL settle time after leaving the substate, before SUB_ACTIVE
    localparam int PLL_SETTLE_NS  = 1000;
    localparam int PLL_SETTLE_CYC =
        (PLL_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Presence input must hold this long before it is believed
    localparam int PRESENCE_DEBOUNCE_NS  = 1000;
    localparam int PRESENCE_DEBOUNCE_CYC =
        (PRESENCE_DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE      = 8'h01;
    localparam logic [CNT_W-1:0] PLL_SETTLE_CNT      = CNT_W'(PLL_SETTLE_CYC);
    localparam logic [CNT_W-1:0] PRESENCE_DEBOUNCE_CNT = CNT_W'(PRESENCE_DEBOUNCE_CYC);

    // Per-port clock-request state, Gray along the usual path
    typedef enum logic [1:0] {
        SUB_ACTIVE = 2'h0,
        SUB_ENTRY  = 2'h1,
        SUB_L1     = 2'h3,
        SUB_WAKE   = 2'h2
    } substate_e;

endpackage

// File: core/port_config_straps.sv
// Operation
// - VC strap: VC1 on, or resources to VC0
// - Polarity strap high disables inversion detection
// - Payload strap selects 512 or 256 bytes
// - Presence low means device in slot
// - Slot clock strap high means common clock
// - Slot-implemented strap: slot, else chip-to-chip
// - L1 substate only while select is low
// - Request released: refclk and PLL off, L1
// - Request asserted: refclk valid, PLL on, exit
// - Select high: per-port status outputs driven
// - System reset initialises all internal state
`timescale 1ns/1ps
`default_nettype none

module port_config_straps (
    input  wire logic       clock_i,                        // Core clock, 40 MHz
    input  wire logic       nrst_i,                         // System reset, active low
    input  wire logic       second_vc_enable_i,             // VC1 strap
    input  wire logic       rx_polarity_detect_disable_i,   // Polarity detect strap
    input  wire logic       payload_large_select_i,         // 512 byte payload strap
    input  wire logic       slot_clock_config_i,            // Slot clock strap
    input  wire logic [3:1] slot_implemented_i,             // Slot attached straps
    input  wire logic [3:1] slot_presence_n_i,              // Presence, active low
    input  wire logic       status_or_substate_select_i,    // Status mode strap
    input  wire logic [3:0] clock_request_n_i,              // Clock request pin level
    input  wire logic [3:0] port_l1_entry_i,                // Port link idle in L1
    input  wire logic [3:0] port_l1_exit_i,                 // Port link wants to leave L1
    input  wire logic [3:0] port_status_i,                  // Port condition for debug
    output var  logic       vc1_enable_o,                   // VC1 capability on
    output var  logic       vc_resource_share_o,            // VC1 resources lent to VC0
    output var  logic       rx_polarity_detect_en_o,        // Inversion detection on
    output var  logic [2:0] max_payload_code_o,             // Max payload capability
    output var  logic       common_clock_o,                 // Platform refclk used
    output var  logic [3:1] slot_attached_o,                // Port goes to a slot
    output var  logic [3:1] slot_present_o,                 // Device in slot
    output var  logic       l1_substate_support_o,          // Substate capability on
    output var  logic [3:0] clock_request_n_o,              // Clock request pin drive
    output var  logic [3:0] clock_request_oe_o,             // Clock request pin enable
    output var  logic [3:0] refclk_enable_o,                // Reference clock on
    output var  logic [3:0] pll_enable_o,                   // PLL on
    output var  logic [3:0] l1_substate_o,                  // Port in L1 substate
    output var  logic [3:0] per_port_status_out_o           // Debug status pins
);

    // Strap capture group
    logic       vc1_r;
    logic       vc1_nxt;
    logic       pol_dis_r;
    logic       pol_dis_nxt;
    logic       pl512_r;
    logic       pl512_nxt;
    logic       slot_clock_config_r;
    logic       slot_clock_config_nxt;
    logic [3:1] slot_implemented_r;
    logic [3:1] slot_implemented_nxt;
    logic       status_mode_r;
    logic       status_mode_nxt;

    always_comb begin
        vc1_nxt         = vc1_r;
        pol_dis_nxt     = pol_dis_r;
        pl512_nxt       = pl512_r;
        slot_clock_config_nxt     = slot_clock_config_r;
        slot_implemented_nxt    = slot_implemented_r;
        status_mode_nxt = status_mode_r;
        // Follow the pins only while reset is held
        if (!nrst_i) begin
            vc1_nxt         = second_vc_enable_i;
            pol_dis_nxt     = rx_polarity_detect_disable_i;
            pl512_nxt       = payload_large_select_i;
            slot_clock_config_nxt     = slot_clock_config_i;
            slot_implemented_nxt    = slot_implemented_i;
            status_mode_nxt = status_or_substate_select_i;
        end
    end

    always_ff @(posedge clock_i) begin
        vc1_r         <= vc1_nxt;
        pol_dis_r     <= pol_dis_nxt;
        pl512_r       <= pl512_nxt;
        slot_clock_config_r     <= slot_clock_config_nxt;
        slot_implemented_r    <= slot_implemented_nxt;
        status_mode_r <= status_mode_nxt;
    end

    // Configuration outputs group
    logic       vc1_out_r;
    logic       vc1_out_nxt;
    logic       share_r;
    logic       share_nxt;
    logic       pol_en_r;
    logic       pol_en_nxt;
    logic [2:0] mps_r;
    logic [2:0] mps_nxt;
    logic       cclk_r;
    logic       cclk_nxt;
    logic [3:1] attached_r;
    logic [3:1] attached_nxt;
    logic       l1s_sup_r;
    logic       l1s_sup_nxt;
    logic [3:0] status_out_r;
    logic [3:0] status_out_nxt;

    always_comb begin
        vc1_out_nxt    = 1'b0;
        share_nxt      = 1'b0;
        pol_en_nxt     = 1'b0;
        mps_nxt        = port_config_pkg::MPS_RESET;
        cclk_nxt       = 1'b0;
        attached_nxt   = 3'h0;
        l1s_sup_nxt    = 1'b0;
        status_out_nxt = 4'h0;
        if (nrst_i) begin
            vc1_out_nxt    = vc1_r;
            share_nxt      = !vc1_r;
            pol_en_nxt     = !pol_dis_r;
            if (pl512_r) begin
                mps_nxt = port_config_pkg::MPS_CODE_512;
            end else begin
                mps_nxt = port_config_pkg::MPS_CODE_256;
            end
            cclk_nxt       = slot_clock_config_r;
            attached_nxt   = slot_implemented_r;
            l1s_sup_nxt    = !status_mode_r;
            // Debug pins carry port state only in status mode
            if (status_mode_r) begin
                status_out_nxt = port_status_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        vc1_out_r    <= vc1_out_nxt;
        share_r      <= share_nxt;
        pol_en_r     <= pol_en_nxt;
        mps_r        <= mps_nxt;
        cclk_r       <= cclk_nxt;
        attached_r   <= attached_nxt;
        l1s_sup_r    <= l1s_sup_nxt;
        status_out_r <= status_out_nxt;
    end

    assign vc1_enable_o            = vc1_out_r;
    assign vc_resource_share_o     = share_r;
    assign rx_polarity_detect_en_o = pol_en_r;
    assign max_payload_code_o      = mps_r;
    assign common_clock_o          = cclk_r;
    assign slot_attached_o         = attached_r;
    assign l1_substate_support_o   = l1s_sup_r;
    assign per_port_status_out_o   = status_out_r;

    // Presence debounce, one per downstream port
    for (genvar d = port_config_pkg::FIRST_DOWN; d <= port_config_pkg::LAST_DOWN;
         d++) begin : g_presence
        logic                              present_r;
        logic                              present_nxt;
        logic [port_config_pkg::CNT_W-1:0] db_cnt_r;
        logic [port_config_pkg::CNT_W-1:0] db_cnt_nxt;

        always_comb begin
            present_nxt = present_r;
            db_cnt_nxt  = port_config_pkg::CNT_ZERO;
            if (!nrst_i) begin
                present_nxt = 1'b0;
            end else if (!slot_presence_n_i[d] != present_r) begin
                db_cnt_nxt = db_cnt_r + port_config_pkg::CNT_ONE;
                if (db_cnt_r >= port_config_pkg::PRESENCE_DEBOUNCE_CNT
                                 - port_config_pkg::CNT_ONE) begin
                    present_nxt = !slot_presence_n_i[d];
                    db_cnt_nxt  = port_config_pkg::CNT_ZERO;
                end
            end
        end

        always_ff @(posedge clock_i) begin
            present_r <= present_nxt;
            db_cnt_r  <= db_cnt_nxt;
        end

        assign slot_present_o[d] = present_r;
    end

    // Clock-request substate control, one per port
    for (genvar p = 0; p < port_config_pkg::NUM_PORTS; p++) begin : g_substate
        port_config_pkg::substate_e        state_r;
        port_config_pkg::substate_e        state_nxt;
        logic [port_config_pkg::CNT_W-1:0] wait_r;
        logic [port_config_pkg::CNT_W-1:0] wait_nxt;
        logic                              oe_r;
        logic                              oe_nxt;
        logic                              ref_r;
        logic                              ref_nxt;
        logic                              pll_r;
        logic                              pll_nxt;
        logic                              in_l1_r;
        logic                              in_l1_nxt;
        logic                              drv_r;
        logic                              drv_nxt;
        logic                              pin_asserted;

        assign pin_asserted = !clock_request_n_i[p];

        always_comb begin
            state_nxt = state_r;
            wait_nxt  = wait_r;
            case (state_r)
                port_config_pkg::SUB_ACTIVE: begin
                    // Release our drive only when substates are allowed
                    if (!status_mode_r && port_l1_entry_i[p]) begin
                        state_nxt = port_config_pkg::SUB_ENTRY;
                    end
                end
                port_config_pkg::SUB_ENTRY: begin
                    if (!port_l1_entry_i[p] || port_l1_exit_i[p]) begin
                        state_nxt = port_config_pkg::SUB_ACTIVE;
                    end else if (!pin_asserted) begin
                        state_nxt = port_config_pkg::SUB_L1;
                    end
                end
                port_config_pkg::SUB_L1: begin
                    // Partner pulls the pin or our own link wants out
                    if (pin_asserted || port_l1_exit_i[p]) begin
                        state_nxt = port_config_pkg::SUB_WAKE;
                        wait_nxt  = port_config_pkg::PLL_SETTLE_CNT;
                    end
                end
                port_config_pkg::SUB_WAKE: begin
                    wait_nxt = wait_r - port_config_pkg::CNT_ONE;
                    if (wait_r <= port_config_pkg::CNT_ONE) begin
                        state_nxt = port_config_pkg::SUB_ACTIVE;
                        wait_nxt  = port_config_pkg::CNT_ZERO;
                    end
                end
                default: begin
                    state_nxt = port_config_pkg::SUB_ACTIVE;
                    wait_nxt  = port_config_pkg::CNT_ZERO;
                end
            endcase
            if (!nrst_i || status_mode_r) begin
                state_nxt = port_config_pkg::SUB_ACTIVE;
                wait_nxt  = port_config_pkg::CNT_ZERO;
            end
        end

        // Outputs follow the state being entered, so they change with it
        always_comb begin
            ref_nxt   = 1'b1;
            pll_nxt   = 1'b1;
            in_l1_nxt = 1'b0;
            oe_nxt    = 1'b0;
            drv_nxt   = 1'b0;
            case (state_nxt)
                port_config_pkg::SUB_ACTIVE: begin
                    // Hold the open-drain request low while the link runs, except in status mode
                    oe_nxt = !status_mode_r;
                end
                port_config_pkg::SUB_ENTRY: begin
                    // Let go so the wire can float to deasserted
                    oe_nxt = 1'b0;
                end
                port_config_pkg::SUB_L1: begin
                    // Clocks off only in the substate itself
                    ref_nxt   = 1'b0;
                    pll_nxt   = 1'b0;
                    in_l1_nxt = 1'b1;
                end
                port_config_pkg::SUB_WAKE: begin
                    oe_nxt = !status_mode_r;
                end
                default: begin
                    oe_nxt = 1'b0;
                end
            endcase
            if (!nrst_i) begin
                ref_nxt   = 1'b1;
                pll_nxt   = 1'b1;
                in_l1_nxt = 1'b0;
                oe_nxt    = 1'b0;
                drv_nxt   = 1'b0;
            end
        end

        always_ff @(posedge clock_i) begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            oe_r    <= oe_nxt;
            ref_r   <= ref_nxt;
            pll_r   <= pll_nxt;
            in_l1_r <= in_l1_nxt;
            drv_r   <= drv_nxt;
        end

        assign clock_request_n_o[p]  = drv_r;
        assign clock_request_oe_o[p] = oe_r;
        assign refclk_enable_o[p]    = ref_r;
        assign pll_enable_o[p]       = pll_r;
        assign l1_substate_o[p]      = in_l1_r;
    end

endmodule

`default_nettype wire

// File: test/port_config_straps_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module port_config_checker (
    input wire logic       clock_i,                // Clock
    input wire logic       nrst_i,                 // Reset, active low
    input wire logic       second_vc_enable_i,     // VC strap
    input wire logic       payload_large_select_i, // Payload strap
    input wire logic [3:0] clock_request_n_i,      // Request wire level
    input wire logic [3:0] port_status_i,          // Port condition
    input wire logic       vc1_enable_o,           // VC1 on
    input wire logic       vc_resource_share_o,    // Sharing on
    input wire logic [2:0] max_payload_code_o,     // Payload code
    input wire logic       l1_substate_support_o,  // Substate mode
    input wire logic [3:0] clock_request_oe_o,     // Request drive
    input wire logic [3:0] refclk_enable_o,        // Refclk on
    input wire logic [3:0] pll_enable_o,           // PLL on
    input wire logic [3:0] l1_substate_o,          // In substate
    input wire logic [3:0] per_port_status_out_o   // Debug pins
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_asleep;
        l1_substate_o[0] && !clock_request_n_i[0];
    endsequence

    sequence s_awake;
        !l1_substate_o[0] && refclk_enable_o[0] && pll_enable_o[0] && clock_request_oe_o[0];
    endsequence

    a_vc_capture: assert property (
        $rose(nrst_i) |=> vc1_enable_o == $past(second_vc_enable_i, 2)
            && vc_resource_share_o != vc1_enable_o) else $error("VC setting wrong");
    a_mps_capture: assert property (
        $rose(nrst_i) |=> max_payload_code_o == ($past(payload_large_select_i, 2)
            ? port_config_pkg::MPS_CODE_512 : port_config_pkg::MPS_CODE_256))
        else $error("Payload code wrong");
    a_cfg_hold: assert property (
        $past(nrst_i) |=> $stable({vc1_enable_o, max_payload_code_o, l1_substate_support_o}))
        else $error("Captured setting moved");
    a_l1_gate: assert property (
        !l1_substate_support_o && $past(nrst_i) |-> l1_substate_o == 4'h0
            && clock_request_oe_o == 4'h0) else $error("Substate used in status mode");
    a_clk_off: assert property (
        (l1_substate_o & (refclk_enable_o | pll_enable_o)) == 4'h0)
        else $error("Clock on in substate");
    a_l1_entry: assert property (
        $rose(l1_substate_o[0]) |-> $past(clock_request_n_i[0]) && !$past(clock_request_oe_o[0]))
        else $error("Substate entered with request held");
    a_l1_wake: assert property (
        s_asleep |=> s_awake) else $error("No wake on request");
    a_status_copy: assert property (
        !l1_substate_support_o && $past(nrst_i) |=> per_port_status_out_o == $past(port_status_i))
        else $error("Status pins wrong");
    a_status_quiet: assert property (
        l1_substate_support_o |-> per_port_status_out_o == 4'h0) else $error("Status pins driven");
endmodule

bind port_config_straps port_config_checker chk (.*);

`default_nettype wire

// File: test/slot_clkreq_model.sv
`timescale 1ns/1ps
`default_nettype none

module slot_clkreq_model (
    input  wire logic [3:0] dev_oe_i, // Device pulls wire
    input  wire logic [3:0] dev_n_i,  // Device drive value
    input  wire logic [3:0] want_i,   // Slot device asks for clock
    output var  logic [3:0] wire_n_o  // Resolved wire level
);
    // Open drain with pull-up, slot pulls low while it needs the clock
    assign wire_n_o = ~((dev_oe_i & ~dev_n_i) | want_i);
endmodule

`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       clock_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic [7:0] straps = 8'h00;
    logic [3:1] slot_presence_n_i = 3'h7;
    logic [3:0] port_l1_entry_i = 4'h0;
    logic [3:0] port_status_i = 4'h0;
    logic [3:0] want = 4'h0;
    logic [3:0] port_l1_exit_i = 4'h0;
    wire        second_vc_enable_i = straps[0], rx_polarity_detect_disable_i = straps[1];
    wire        payload_large_select_i = straps[2], slot_clock_config_i = straps[3];
    wire  [3:1] slot_implemented_i = straps[6:4];
    wire        status_or_substate_select_i = straps[7];
    wire  [3:0] clock_request_n_i;
    logic       vc1_enable_o, vc_resource_share_o, rx_polarity_detect_en_o;
    logic       common_clock_o, l1_substate_support_o;
    logic [2:0] max_payload_code_o;
    logic [3:1] slot_attached_o, slot_present_o;
    logic [3:0] clock_request_n_o, clock_request_oe_o, refclk_enable_o;
    logic [3:0] pll_enable_o, l1_substate_o, per_port_status_out_o;
    int         err_count = 0;
    int         check_count = 0;

    port_config_straps dut (.*);
    slot_clkreq_model partner (.dev_oe_i(clock_request_oe_o), .dev_n_i(clock_request_n_o),
                               .want_i(want), .wire_n_o(clock_request_n_i));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    // Straps flip at release, so only the in-reset value may show
    task automatic reset_with(input logic [7:0] s);
        logic [2:0] mps;
        mps = s[2] ? port_config_pkg::MPS_CODE_512 : port_config_pkg::MPS_CODE_256;
        @(posedge clock_i);
        nrst_i <= 1'b0;
        straps <= s;
        tick(4);
        check({refclk_enable_o, pll_enable_o}, 8'hFF);
        check({vc1_enable_o, max_payload_code_o, clock_request_oe_o}, 8'h00);
        @(posedge clock_i);
        nrst_i <= 1'b1;
        straps <= ~s;
        tick(2);
        check({vc1_enable_o, vc_resource_share_o}, {6'h00, s[0], !s[0]});
        check(rx_polarity_detect_en_o, !s[1]);
        check(max_payload_code_o, mps);
        check(common_clock_o, s[3]);
        check(slot_attached_o, s[6:4]);
        check({l1_substate_support_o, clock_request_oe_o}, s[7] ? 8'h00 : 8'h1F);
    endtask

    task automatic status_mode();
        @(posedge clock_i);
        port_status_i <= 4'hA;
        port_l1_entry_i <= 4'hF;
        tick(1);
        check(per_port_status_out_o, 8'h0A);
        @(posedge clock_i) port_status_i <= 4'h5;
        tick(3);
        check({per_port_status_out_o, l1_substate_o}, 8'h50);
        @(posedge clock_i) port_l1_entry_i <= 4'h0;
    endtask

    // A one-cycle glitch restarts the debounce count
    task automatic presence();
        @(posedge clock_i) slot_presence_n_i <= 3'h0;
        repeat (38) @(posedge clock_i);
        slot_presence_n_i <= 3'h7;
        @(posedge clock_i) slot_presence_n_i <= 3'h0;
        tick(39);
        check(slot_present_o, 8'h00);
        tick(1);
        check(slot_present_o, 8'h07);
        @(posedge clock_i) slot_presence_n_i <= 3'h7;
        tick(40);
        check(slot_present_o, 8'h00);
    endtask

    task automatic l1_cycle();
        check(per_port_status_out_o, 8'h00);
        @(posedge clock_i) port_l1_entry_i <= 4'h1;
        tick(1);
        check(clock_request_oe_o, 8'h0E);
        tick(1);
        check({l1_substate_o, refclk_enable_o}, 8'h1E);
        tick(5);
        check({l1_substate_o, pll_enable_o}, 8'h1E);
        check(clock_request_n_o, 8'h00);
        @(posedge clock_i) want <= 4'h1;
        tick(1);
        check({l1_substate_o, refclk_enable_o}, 8'h0F);
        check({pll_enable_o, clock_request_oe_o}, 8'hFF);
        // Entry stays high: the drive drops one cycle after the settle wait ends
        tick(40);
        check(clock_request_oe_o, 8'h0F);
        tick(1);
        check({l1_substate_o, clock_request_oe_o}, 8'h0E);
        @(posedge clock_i) want <= 4'h0;
        tick(1);
        check({l1_substate_o, refclk_enable_o}, 8'h1E);
        @(posedge clock_i) port_l1_exit_i <= 4'h1;
        tick(1);
        check({l1_substate_o, pll_enable_o}, 8'h0F);
        @(posedge clock_i) begin
            port_l1_exit_i <= 4'h0;
            port_l1_entry_i <= 4'h0;
        end
        tick(45);
        check({l1_substate_o, clock_request_oe_o}, 8'h0F);
    endtask

    initial begin
        reset_with(8'hAD);
        status_mode();
        presence();
        reset_with(8'h52);
        l1_cycle();
        test_done();
    end
endmodule

`default_nettype wire
